// >>> common/lcd_ctrl_defs.svh
// Constants for the display controller standby, reset and command logic.
// Assumes a 20 MHz system clock and APB byte addressing of word-aligned registers.
`ifndef LCD_CTRL_DEFS_SVH
`define LCD_CTRL_DEFS_SVH
// ==========================================
// Timing
`define CLK_NS 50
`define BUSY_NS 1000
// ==========================================
// APB register offsets
`define REG_STATUS 12'h000
`define REG_CMD 12'h004
// ==========================================
// Reset values and strap bit positions
`define ADDR_RST 2'h0
`define PTR_RST 7'h00
`define MUX_RST 3'h0
`define FRAME_RST 3'h0
`define STRAP_PS_BIT 1
`define STRAP_CAE_BIT 2
// ==========================================
// Command codes and field limits
`define CMD_STOP 8'h01
`define CMD_BLANK 8'h08
`define CMD_SHOW 8'h09
`define CMD_FRAME_HI 5'h02
`define FRAME_MAX 3'h4
`define CMD_MUX_HI 5'h03
`define PTR_MAX 6'h31
`define CMD_MODE_HI 4'h6
`define CMD_CHAR_L 8'h71
`define CMD_CHAR_R 8'h72
`define STEP_INC 2'h0
`define STEP_DEC 2'h1
`define STEP_BAD 2'h2
`endif

// >>> common/lcd_ctrl_pkg.sv
// Types shared by the controller modules.
// Assumes lcd_ctrl_defs.svh supplies the numeric constants.
package lcd_ctrl_pkg;
    // ==========================================
    // Data processing modes; the first four are encoded as the command low nibble pair
    typedef enum logic [2:0] {
        MODE_READ = 3'h0,
        MODE_WRITE = 3'h1,
        MODE_OR = 3'h2,
        MODE_AND = 3'h3,
        MODE_CHAR_L = 3'h4,
        MODE_CHAR_R = 3'h5
    } proc_mode_type;
    // Controller states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_BUSY = 4'h2,
        ST_STANDBY = 4'h4,
        ST_HALT = 4'h8
    } ctrl_state_type;
endpackage : lcd_ctrl_pkg

// >>> logic/byte_port_rx.sv
// Serial or 4-bit parallel byte receiver with chip address matching.
// Assumes all port pins are synchronous to clk_sys; hold is the reset pin.
`timescale 1ns/1ps
`include "lcd_ctrl_defs.svh"
module byte_port_rx
    import lcd_ctrl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic hold,
    input wire logic parallel,
    input wire logic cae,
    input wire logic cs_n,
    input wire logic strobe_n,
    input wire logic si,
    input wire logic [3:0] d_in,
    input wire logic [1:0] chip_id,
    output logic byte_done,
    output logic [7:0] rx_byte,
    output logic selected
);
    logic cs_n_q;
    logic stb_q;
    logic addr_wait_q;
    logic [1:0] cmp_q;
    logic [2:0] cnt_q;
    logic [7:0] shift_q;
    logic cs_fall;
    logic stb_rise;
    logic stb_fall;
    logic [2:0] last;
    assign cs_fall = cs_n_q & ~cs_n;
    assign stb_rise = ~stb_q & strobe_n;
    assign stb_fall = stb_q & ~strobe_n;
    assign last = parallel ? 3'h4 : 3'h7;
    assign selected = (cmp_q == chip_id);
    assign rx_byte = shift_q;
    // Pin history for edge detection
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cs_n_q <= 1'b1;
            stb_q <= 1'b1;
        end else begin
            cs_n_q <= cs_n;
            stb_q <= strobe_n;
        end
    end
    // Address capture and bit or nibble counting
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cmp_q <= `ADDR_RST;
            addr_wait_q <= 1'b0;
            cnt_q <= 3'h0;
            shift_q <= 8'h00;
            byte_done <= 1'b0;
        end else if (hold) begin
            cmp_q <= `ADDR_RST;
            addr_wait_q <= 1'b0;
            cnt_q <= 3'h0;
            byte_done <= 1'b0;
        end else begin
            byte_done <= 1'b0;
            if (cs_fall) begin
                addr_wait_q <= parallel | cae;
                cnt_q <= 3'h0;
            end else if (!cs_n && parallel && addr_wait_q && stb_fall) begin
                cmp_q <= d_in[1:0];
                addr_wait_q <= 1'b0;
            end else if (!cs_n && stb_rise && (selected || addr_wait_q)) begin
                shift_q <= parallel ? {shift_q[3:0], d_in} : {shift_q[6:0], si};
                // Three bits wrap to zero after a whole byte
                cnt_q <= cnt_q + (parallel ? 3'h4 : 3'h1);
                if (cnt_q == last) begin
                    if (addr_wait_q) begin
                        cmp_q <= {shift_q[0], si};
                        addr_wait_q <= 1'b0;
                    end else begin
                        byte_done <= 1'b1;
                    end
                end
            end
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    chk_addr_clear: assert property (hold |=> cmp_q == `ADDR_RST)
        else $error("address compare not cleared by reset");
    chk_done_edge: assert property (byte_done |-> $past(stb_rise) && cnt_q == 3'h0)
        else $error("byte completed off a strobe edge");
endmodule : byte_port_rx

// >>> logic/frame_tick_div.sv
// Frame rate divider; one-cycle tick every 2^(LOG2-field) clocks.
// Assumes run is low whenever the display clock is masked.
`timescale 1ns/1ps
module frame_tick_div #(
    parameter int unsigned LOG2 = 14
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic run,
    input wire logic [2:0] frame_div,
    output logic tick
);
    logic [LOG2-1:0] cnt_q;
    logic [LOG2-1:0] limit;
    assign limit = LOG2'((1 << (LOG2 - 32'(frame_div))) - 1);
    // Counter freezes while masked instead of resetting
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (run) begin
                if (cnt_q >= limit) begin
                    cnt_q <= '0;
                    tick <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                end
            end
        end
    end
    chk_gate_freeze: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !run |=> $stable(cnt_q) && !tick)
        else $error("frame divider ran while masked");
endmodule : frame_tick_div

// >>> logic/lcd_standby_reset_command_control.sv
// Command decoder, standby and reset control for a dot-matrix display controller.
// Assumes port pins and the reset pin are synchronous to clk_sys; APB slave.
//
// Behaviour
// - Standby begins when busy rises after the standby command 01 finishes.
// - In standby the display timing and clock control are masked off.
// - Entering standby forces write mode with pointer step 00.
// - Standby keeps interface configuration and display mode settings.
// - Standby ends on a complete received byte or reset falling edge.
// - Byte wake happens at 8th serial clock or 2nd nibble strobe rise.
// - Serial address mode: first byte after select is address, next byte wakes.
// - Display drive outputs hold their last level during standby while reset is low.
// - Reset in standby drives reset levels but keeps memory contents.
// - Reset clears the chip address compare value to 00.
// - In reset, id 00 drives busy low when selected, others float.
// - Reset halts command and data processing and display fetching.
// - Reset sets write mode, step 00 and clears the pointer.
// - Reset sets multiplex field 000 and frame divider field 000.
// - Reset clears the byte transfer counter.
// - Reset during standby keeps standby until reset is released.
// - Reset release samples the straps and blanks the display.
// - After reset a chip with id 00 is selected.
// - Decode standby, blank, show, frame rate and multiplex commands.
// - Decode pointer load and mode command ranges.
`timescale 1ns/1ps
`include "lcd_ctrl_defs.svh"
module lcd_standby_reset_command_control
    import lcd_ctrl_pkg::*;
#(
    parameter int unsigned FRAME_LOG2 = 14
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_in,
    input wire logic cs_n,
    input wire logic nibble_strobe_n,
    input wire logic si,
    input wire logic [3:0] d_in,
    input wire logic cmd_data_sel,
    input wire logic [1:0] chip_id_pins,
    output logic busy_n,
    output logic busy_oe,
    output logic standby,
    output logic clk_run,
    output logic drive_hold,
    output logic drive_bias,
    output logic display_on,
    output logic frame_tick,
    output proc_mode_type proc_mode,
    output logic [1:0] pointer_step_field,
    output logic [6:0] pointer_value_field,
    output logic [2:0] mux_field,
    output logic [2:0] frame_div_field,
    output logic mem_kept,
    output logic parallel_mode,
    output logic address_match_enable_strap
);
    // ==========================================
    // Timing derived from the system clock
    localparam int BUSY_CYC = (`BUSY_NS + `CLK_NS - 1) / `CLK_NS;
    localparam logic [7:0] BUSY_LAST = 8'(BUSY_CYC - 1);

    ctrl_state_type state_q;
    logic [7:0] busy_cnt_q;
    logic stop_pend_q;
    logic reset_q;
    logic rst_fall;
    logic rx_done;
    logic [7:0] rx_byte;
    logic selected;
    logic apb_inject;
    logic byte_in;
    logic [7:0] in_byte;
    logic in_cmd;
    logic exec;
    logic busy_end;
    logic enter_standby;

    // ==========================================
    // Byte port receiver; held while the reset pin is high
    byte_port_rx u_rx (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .hold(reset_in),
        .parallel(parallel_mode),
        .cae(address_match_enable_strap),
        .cs_n(cs_n),
        .strobe_n(nibble_strobe_n),
        .si(si),
        .d_in(d_in),
        .chip_id(chip_id_pins),
        .byte_done(rx_done),
        .rx_byte(rx_byte),
        .selected(selected)
    );

    // ==========================================
    // Frame divider runs only from the masked clock enable
    frame_tick_div #(
        .LOG2(FRAME_LOG2)
    ) u_div (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .run(clk_run),
        .frame_div(frame_div_field),
        .tick(frame_tick)
    );

    // Byte source select; the pin port wins over an APB injection
    assign byte_in = rx_done | apb_inject;
    assign in_byte = rx_done ? rx_byte : pwdata[7:0];
    assign in_cmd = rx_done ? cmd_data_sel : 1'b1;
    assign rst_fall = reset_q & ~reset_in;
    assign exec = byte_in & ~reset_in & ((state_q == ST_IDLE) | (state_q == ST_STANDBY));
    assign busy_end = (state_q == ST_BUSY) && (busy_cnt_q == BUSY_LAST);
    assign enter_standby = busy_end & stop_pend_q & ~reset_in;

    // ==========================================
    // Command decode
    logic c_stop;
    logic c_blank;
    logic c_show;
    logic c_frame;
    logic c_mux;
    logic c_ptr;
    logic c_mode;
    proc_mode_type new_mode;
    always_comb begin
        c_stop = in_cmd && (in_byte == `CMD_STOP);
        c_blank = in_cmd && (in_byte == `CMD_BLANK);
        c_show = in_cmd && (in_byte == `CMD_SHOW);
        // Dividers above the last legal one are dropped
        c_frame = in_cmd && (in_byte[7:3] == `CMD_FRAME_HI) && (in_byte[2:0] <= `FRAME_MAX);
        c_mux = in_cmd && (in_byte[7:3] == `CMD_MUX_HI);
        // Both pointer ranges share the same low-six-bit limit
        c_ptr = in_cmd && in_byte[7] && (in_byte[5:0] <= `PTR_MAX);
        c_mode = in_cmd && (((in_byte[7:4] == `CMD_MODE_HI) && (in_byte[1:0] != `STEP_BAD))
            || (in_byte == `CMD_CHAR_L) || (in_byte == `CMD_CHAR_R));
        if (in_byte == `CMD_CHAR_L) begin
            new_mode = MODE_CHAR_L;
        end else if (in_byte == `CMD_CHAR_R) begin
            new_mode = MODE_CHAR_R;
        end else begin
            new_mode = proc_mode_type'({1'b0, in_byte[3:2]});
        end
    end

    // ==========================================
    // Reset pin history for the release edge
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reset_q <= 1'b0;
        end else begin
            reset_q <= reset_in;
        end
    end

    // ==========================================
    // Control state machine
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_HALT;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (reset_in) begin
                        state_q <= ST_HALT;
                    end else if (exec) begin
                        state_q <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    if (reset_in) begin
                        state_q <= ST_HALT;
                    end else if (busy_end) begin
                        state_q <= stop_pend_q ? ST_STANDBY : ST_IDLE;
                    end
                end
                ST_STANDBY: begin
                    // Reset high keeps standby; its release wakes
                    if (rst_fall) begin
                        state_q <= ST_IDLE;
                    end else if (exec) begin
                        state_q <= ST_BUSY;
                    end
                end
                ST_HALT: begin
                    if (!reset_in) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Busy timer and pending standby request
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy_cnt_q <= 8'h00;
            stop_pend_q <= 1'b0;
        end else if (exec) begin
            busy_cnt_q <= 8'h00;
            stop_pend_q <= c_stop;
        end else if (state_q == ST_BUSY) begin
            busy_cnt_q <= busy_cnt_q + 8'h01;
            if (busy_end || reset_in) begin
                stop_pend_q <= 1'b0;
            end
        end
    end

    // ==========================================
    // Processing mode and data pointer
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            proc_mode <= MODE_WRITE;
            pointer_step_field <= `STEP_INC;
            pointer_value_field <= `PTR_RST;
        end else if (reset_in) begin
            proc_mode <= MODE_WRITE;
            pointer_step_field <= `STEP_INC;
            pointer_value_field <= `PTR_RST;
        end else if (enter_standby) begin
            proc_mode <= MODE_WRITE;
            pointer_step_field <= `STEP_INC;
        end else if (exec) begin
            if (c_mode) begin
                proc_mode <= new_mode;
                // Character modes always walk forward
                pointer_step_field <= in_byte[6:4] == 3'h7 ? `STEP_INC : in_byte[1:0];
            end else if (c_ptr) begin
                pointer_value_field <= in_byte[6:0];
            end else if (!in_cmd) begin
                if (pointer_step_field == `STEP_INC) begin
                    pointer_value_field <= pointer_value_field + 7'h01;
                end else if (pointer_step_field == `STEP_DEC) begin
                    pointer_value_field <= pointer_value_field - 7'h01;
                end
            end
        end
    end

    // ==========================================
    // Display mode settings; standby never touches these
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mux_field <= `MUX_RST;
            frame_div_field <= `FRAME_RST;
            display_on <= 1'b0;
        end else if (reset_in) begin
            mux_field <= `MUX_RST;
            frame_div_field <= `FRAME_RST;
            display_on <= 1'b0;
        end else if (exec) begin
            if (c_mux) begin
                mux_field <= in_byte[2:0];
            end
            if (c_frame) begin
                frame_div_field <= in_byte[2:0];
            end
            if (c_blank) begin
                display_on <= 1'b0;
            end else if (c_show) begin
                display_on <= 1'b1;
            end
        end
    end

    // ==========================================
    // Interface straps, caught only on the reset release edge
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            parallel_mode <= 1'b0;
            address_match_enable_strap <= 1'b0;
        end else if (rst_fall) begin
            parallel_mode <= d_in[`STRAP_PS_BIT];
            address_match_enable_strap <= d_in[`STRAP_CAE_BIT];
        end
    end

    // ==========================================
    // Memory retention flag: reset outside standby spoils memory
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mem_kept <= 1'b0;
        end else if (reset_in && state_q != ST_STANDBY) begin
            mem_kept <= 1'b0;
        end else if (exec && !in_cmd && proc_mode != MODE_READ) begin
            mem_kept <= 1'b1;
        end
    end

    // ==========================================
    // Clock masking and drive level outputs
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            standby <= 1'b0;
            clk_run <= 1'b0;
            drive_hold <= 1'b0;
            drive_bias <= 1'b1;
        end else begin
            standby <= (state_q == ST_STANDBY);
            clk_run <= (state_q != ST_STANDBY) && !reset_in;
            drive_hold <= (state_q == ST_STANDBY) && !reset_in;
            drive_bias <= reset_in;
        end
    end

    // ==========================================
    // Busy pin; rises the same edge standby begins
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy_n <= 1'b1;
            busy_oe <= 1'b0;
        end else if (reset_in) begin
            busy_n <= 1'b0;
            busy_oe <= (chip_id_pins == `ADDR_RST) && !cs_n;
        end else begin
            busy_n <= !(exec || (state_q == ST_BUSY && !busy_end));
            busy_oe <= !cs_n && selected;
        end
    end

    // ==========================================
    // APB slave: one wait state, error on unmapped offsets
    logic apb_acc;
    logic map_hit;
    assign apb_acc = psel & penable;
    assign map_hit = (paddr == `REG_STATUS) || (paddr == `REG_CMD);
    // Command writes only land while the controller can take a byte
    assign apb_inject = apb_acc & pready & pwrite & (paddr == `REG_CMD) & ~rx_done;
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_acc & ~pready;
            if (apb_acc && !pready) begin
                pslverr <= !map_hit;
                prdata <= (!pwrite && paddr == `REG_STATUS) ?
                    {8'h00, standby, display_on, parallel_mode, address_match_enable_strap,
                     !busy_n, mem_kept, proc_mode, pointer_step_field, mux_field,
                     frame_div_field, pointer_value_field} : 32'h0000_0000;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // ==========================================
    // Checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    sequence stop_done_s;
        state_q == ST_BUSY && stop_pend_q && busy_cnt_q == BUSY_LAST && !reset_in;
    endsequence
    sequence standby_idle_s;
        state_q == ST_STANDBY && !exec && !reset_in && !rst_fall;
    endsequence
    chk_stop_entry: assert property (stop_done_s |=> state_q == ST_STANDBY && busy_n)
        else $error("standby not entered with busy high");
    chk_standby_mode: assert property (stop_done_s |=> proc_mode == MODE_WRITE
        && pointer_step_field == `STEP_INC)
        else $error("standby did not force write increment");
    chk_clock_mask: assert property (state_q == ST_STANDBY |=> !clk_run)
        else $error("clock not masked in standby");
    chk_keep_config: assert property (standby_idle_s |=> $stable(mux_field)
        && $stable(frame_div_field) && $stable(parallel_mode) && $stable(display_on))
        else $error("standby altered settings");
    chk_wake_byte: assert property (state_q == ST_STANDBY && exec && !c_stop |=> state_q == ST_BUSY
        ##[1:300] state_q == ST_IDLE)
        else $error("byte did not wake from standby");
    chk_reset_standby: assert property (state_q == ST_STANDBY && reset_in |=>
        state_q == ST_STANDBY)
        else $error("reset left standby early");
    chk_reset_fields: assert property (reset_in |=> pointer_value_field == `PTR_RST
        && mux_field == `MUX_RST && frame_div_field == `FRAME_RST && !display_on)
        else $error("reset values not applied");
    chk_busy_float: assert property (reset_in && chip_id_pins != `ADDR_RST |=> !busy_oe)
        else $error("unaddressed chip drove busy in reset");
endmodule : lcd_standby_reset_command_control

// >>> test/lcd_host_model.sv
// Host CPU model: serial byte sender and reset pin driver.
// Assumes the device samples its port pins on clk_sys.
`timescale 1ns/1ps
module lcd_host_model (
    input wire logic clk_sys,
    output logic reset_in,
    output logic cs_n,
    output logic nibble_strobe_n,
    output logic si,
    output logic [3:0] d_in,
    output logic cmd_data_sel
);
    // ==========================================
    // Idle pins: reset held, serial clock parked high, straps pick serial mode
    initial begin
        reset_in = 1'b1;
        cs_n = 1'b0;
        nibble_strobe_n = 1'b1;
        si = 1'b0;
        d_in = 4'h0;
        cmd_data_sel = 1'b1;
    end
    // MSB first, data steady across each rising shift edge
    task automatic send_byte(input logic cmd, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk_sys) nibble_strobe_n <= 1'b0;
            si <= b[i];
            cmd_data_sel <= cmd;
            repeat (2) @(posedge clk_sys);
            nibble_strobe_n <= 1'b1;
            repeat (2) @(posedge clk_sys);
        end
        // Released line shows the inverse so a stale bit is never trusted
        si <= ~b[0];
    endtask : send_byte
    // Caller raises reset only after busy is seen high again
    task automatic set_reset(input logic v);
        @(posedge clk_sys) reset_in <= v;
    endtask : set_reset
endmodule : lcd_host_model

// >>> test/tb_lcd_standby_reset_command_control.sv
// Self-checking bench for the standby, reset and command control.
// Assumes the host model drives the byte port; APB answers are queued.
`timescale 1ns/1ps
module tb_lcd_standby_reset_command_control
    import lcd_ctrl_pkg::*;
;
    logic clk_sys = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, reset_in, cs_n, strobe_n, si, cmd_data_sel, busy_n, standby, clk_run, display_on, mem_kept;
    logic [3:0] d_in;
    logic [1:0] step, chip_id = 2'h0;
    logic busy_oe;
    logic [2:0] mux, frame, f;
    proc_mode_type mode;
    int failures = 0, checks = 0;
    logic [32:0] q[$], ex;
    always #25 clk_sys = ~clk_sys;
    lcd_host_model host (.clk_sys(clk_sys), .reset_in(reset_in), .cs_n(cs_n), .nibble_strobe_n(strobe_n),
        .si(si), .d_in(d_in), .cmd_data_sel(cmd_data_sel));
    lcd_standby_reset_command_control #(.FRAME_LOG2(4)) u_lcd_standby_reset_command_control (
        .clk_sys(clk_sys), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_in(reset_in), .cs_n(cs_n),
        .nibble_strobe_n(strobe_n), .si(si), .d_in(d_in), .cmd_data_sel(cmd_data_sel), .chip_id_pins(chip_id),
        .busy_n(busy_n), .busy_oe(busy_oe), .standby(standby), .clk_run(clk_run), .drive_hold(), .drive_bias(),
        .display_on(display_on), .frame_tick(), .proc_mode(mode), .pointer_step_field(step),
        .pointer_value_field(), .mux_field(mux), .frame_div_field(frame), .mem_kept(mem_kept),
        .parallel_mode(), .address_match_enable_strap());
    // ==========================================
    // Checks and verdict
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (e !== s) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic give_verdict();
        if (failures == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict
    // Oldest queued response is matched at every answer
    always @(posedge clk_sys) begin
        if (pready === 1'b1) begin
            if (q.size() == 0) chk("apb_extra", 8'h0, 8'h1);
            else begin
                ex = q.pop_front();
                chk("pslverr", {7'h0, ex[32]}, {7'h0, pslverr});
                chk("prdata", ex[31:0], prdata);
            end
        end
    end
    // ==========================================
    // APB master and completion wait, both bounded
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d, input logic err,
        input logic [31:0] r);
        int n;
        q.push_back({err, r});
        @(posedge clk_sys) psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h0, d};
        @(posedge clk_sys) penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            failures++;
            give_verdict();
        end
    endtask : apb
    task automatic wait_idle();
        int n;
        repeat (4) @(posedge clk_sys);
        for (n = 0; busy_n !== 1'b1 && n < 200; n++) @(posedge clk_sys);
        if (n >= 200) begin
            failures++;
            give_verdict();
        end
        repeat (2) @(posedge clk_sys);
    endtask : wait_idle
    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(32'h7045));
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        host.set_reset(1'b0);
        repeat (3) @(posedge clk_sys);
        chk("mux", 8'h0, {5'h0, mux});
        chk("frame", 8'h0, {5'h0, frame});
        chk("mode", MODE_WRITE, mode);
        chk("step", 8'h0, {6'h0, step});
        chk("disp", 8'h0, {7'h0, display_on});
        host.send_byte(1'b1, 8'h09);
        wait_idle();
        chk("disp", 8'h1, {7'h0, display_on});
        apb(12'h004, 1'b1, 8'h1B, 1'b0, 32'h0);
        wait_idle();
        chk("mux", 8'h3, {5'h0, mux});
        f = 3'($urandom_range(4));
        host.send_byte(1'b1, {5'h02, f});
        wait_idle();
        host.send_byte(1'b1, 8'h17);
        wait_idle();
        chk("frame", {5'h0, f}, {5'h0, frame});
        host.send_byte(1'b1, 8'h63);
        wait_idle();
        chk("mode", MODE_READ, mode);
        host.send_byte(1'b1, 8'h01);
        wait_idle();
        chk("stby", 8'h1, {7'h0, standby});
        chk("clkrun", 8'h0, {7'h0, clk_run});
        chk("mode", {MODE_WRITE, 2'h0}, {mode, step});
        chk("keep", {1'b0, 3'h3, f, 1'b1}, {1'b0, mux, frame, display_on});
        host.send_byte(1'b0, 8'($urandom));
        wait_idle();
        chk("stby", 8'h0, {7'h0, standby});
        host.send_byte(1'b1, 8'h01);
        wait_idle();
        host.set_reset(1'b1);
        repeat (4) @(posedge clk_sys);
        chk("stby", 8'h1, {7'h0, standby});
        chk("oe", 8'h1, {7'h0, busy_oe});
        chip_id <= 2'h2;
        repeat (2) @(posedge clk_sys);
        chk("oe", 8'h0, {7'h0, busy_oe});
        chip_id <= 2'h0;
        host.set_reset(1'b0);
        repeat (4) @(posedge clk_sys);
        chk("stby", 8'h0, {7'h0, standby});
        chk("kept", 8'h1, {7'h0, mem_kept});
        chk("mux", 8'h0, {5'h0, mux});
        host.send_byte(1'b1, 8'hB1);
        wait_idle();
        apb(12'h008, 1'b0, 8'h00, 1'b1, 32'h0);
        apb(12'h000, 1'b0, 8'h00, 1'b0, 32'h0004_8031);
        repeat (3) @(posedge clk_sys);
        give_verdict();
    end
endmodule : tb_lcd_standby_reset_command_control
